// *** apcm_regs.vh ***
`ifndef APCM_REGS_VH
`define APCM_REGS_VH
`define APCM_WORD_BITS 8
`define APCM_BIT_CNT_W 4
`define APCM_SIGN_POS 7
`define APCM_SEG_MSB 6
`define APCM_SEG_LSB 4
`define APCM_STEP_MSB 3
`define APCM_STEP_LSB 0
`define APCM_IDLE_WORD 8'h80
`define APCM_RX_GAP_MCLK 17
`define APCM_MCLK_DIV 12
`define APCM_MCLK_CNT_W 4
`endif

// *** apcm_serial_port.v ***
`timescale 1ns/100ps
`include "apcm_regs.vh"

// Behaviour
// [R1] conversion clock unrelated to syncs and clocks
// [R2] tx sync rise enables output, starts conversion
// [R3] shift output bits on tx clock rise
// [R4] drive output only while tx sync high
// [R5] tx sync fall tri-states output
// [R6] controller holds tx sync low one period
// [R7] unload 8-bit register at tx clock rate
// [R8] late tx sync rise gives first shift edge
// [R9] receive bits on rx clock, sync synchronous
// [R10] controller drops rx sync before ninth edge
// [R11] decode word only after rx sync falls
// [R12] controller holds rx sync low seventeen periods
// [R13] capture input bit on gated rx clock rise
// [R14] late rx sync rise gives first capture edge
// [R15] word is sign, three segment, four step
// [R16] segment codes 101 100 111 110 001 000 011 010
// [R17] smallest step twice, then doubling per segment
// [R18] sign one positive, zero negative
// [R19] received word uses same field meanings
// [R20] syncs return low between words
// [R21] offset null before each conversion, sign untouched; code pulses null_cycle_o in the same cycle as conv_start_o
// [R22] controller repeats syncs at 8 kHz
// [R23] first rx bit loaded with sync and clock high
// [R24] words travel msb first, sign leading
module apcm_serial_port (
  input wire clk_i,
  input wire reset_i,
  input wire tx_frame_sync_i,
  input wire tx_bit_clock_i,
  input wire rx_frame_sync_i,
  input wire rx_bit_clock_i,
  input wire rx_data_i,
  input wire sample_sign_i,
  input wire [11:0] sample_mag_i,
  output reg tx_data_o,
  output reg tx_data_oe_o,
  output reg conv_start_o,
  output reg null_cycle_o,
  output reg [7:0] rx_word_o,
  output reg rx_word_valid_o,
  output reg rx_sign_o,
  output reg [11:0] rx_mag_o
);

  // two-flop synchronisers for every link pin (syncs, clocks, rx data)
  reg [1:0] txs_s;
  reg [1:0] txc_s;
  reg [1:0] rxs_s;
  reg [1:0] rxc_s;
  reg [1:0] rxd_s;
  reg txs_d;
  reg txc_d;
  reg rxs_d;
  reg rxc_d;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      txs_s <= 2'b00;
      txc_s <= 2'b00;
      rxs_s <= 2'b00;
      rxc_s <= 2'b00;
      rxd_s <= 2'b00;
      txs_d <= 1'b0;
      txc_d <= 1'b0;
      rxs_d <= 1'b0;
      rxc_d <= 1'b0;
    end
    else
    begin
      txs_s <= {txs_s[0], tx_frame_sync_i};
      txc_s <= {txc_s[0], tx_bit_clock_i};
      rxs_s <= {rxs_s[0], rx_frame_sync_i};
      rxc_s <= {rxc_s[0], rx_bit_clock_i};
      rxd_s <= {rxd_s[0], rx_data_i};
      txs_d <= txs_s[1];
      txc_d <= txc_s[1];
      rxs_d <= rxs_s[1];
      rxc_d <= rxc_s[1];
    end
  end

  wire tx_sync = txs_s[1];
  wire tx_sync_rise = tx_sync & ~txs_d;
  wire tx_sync_fall = ~tx_sync & txs_d;
  wire tx_clk_rise = txc_s[1] & ~txc_d;
  wire rx_sync = rxs_s[1];
  wire rx_sync_rise = rx_sync & ~rxs_d;
  wire rx_sync_fall = ~rx_sync & rxs_d;
  wire rx_clk_rise = rxc_s[1] & ~rxc_d;

  // conversion clock: divided enable, no relation to the link clocks
  reg [`APCM_MCLK_CNT_W-1:0] mclk_cnt;
  wire mclk_en = (mclk_cnt == `APCM_MCLK_CNT_W'd0); // [R1]

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      mclk_cnt <= `APCM_MCLK_CNT_W'd0;
    else if (mclk_cnt == `APCM_MCLK_DIV - 1)
      mclk_cnt <= `APCM_MCLK_CNT_W'd0;
    else
      mclk_cnt <= mclk_cnt + `APCM_MCLK_CNT_W'd1;
  end

  // a-law compressor of a 12-bit magnitude
  function [6:0] apcm_compress;
    input [11:0] mag;
    reg [2:0] seg;
    reg [3:0] step;
    begin
      seg = 3'd7;
      step = mag[10:7];
      if (mag[11])
      begin
        seg = 3'd7;
        step = 4'hf;
      end
      else if (mag[10])
        step = mag[9:6];
      else if (mag[9])
      begin
        seg = 3'd6;
        step = mag[8:5];
      end
      else if (mag[8])
      begin
        seg = 3'd5;
        step = mag[7:4];
      end
      else if (mag[7])
      begin
        seg = 3'd4;
        step = mag[6:3];
      end
      else if (mag[6])
      begin
        seg = 3'd3;
        step = mag[5:2];
      end
      else if (mag[5])
      begin
        seg = 3'd2;
        step = mag[4:1];
      end
      else
      begin
        seg = {2'b00, mag[4]}; // [R17]
        step = mag[3:0];
      end
      if (~mag[11] & ~mag[10] & ~mag[9] & ~mag[8] & ~mag[7] & ~mag[6] & ~mag[5])
        seg = {2'b00, mag[4]};
      apcm_compress = {seg ^ 3'b101, step}; // [R16]
    end
  endfunction

  // a-law expander to a 12-bit magnitude (midpoint of the step in segments 2 to 7, step value in segment 0, 16 plus step in segment 1)
  function [11:0] apcm_expand;
    input [6:0] code;
    reg [2:0] seg;
    reg [11:0] base;
    begin
      seg = code[6:4] ^ 3'b101; // [R16] [R19]
      base = {7'h00, code[3:0], 1'b1};
      if (seg == 3'd0)
        apcm_expand = {8'h00, code[3:0]};
      else if (seg == 3'd1)
        apcm_expand = {7'h00, 1'b1, code[3:0]}; // [R17]
      else
        apcm_expand = (base | 12'h020) << (seg - 3'd2);
    end
  endfunction

  // transmit side
  reg [`APCM_WORD_BITS-1:0] tx_shift;
  reg [`APCM_BIT_CNT_W-1:0] tx_cnt;
  reg conv_pend;
  reg first_edge;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_shift <= `APCM_IDLE_WORD;
      tx_cnt <= `APCM_BIT_CNT_W'd0;
      tx_data_o <= 1'b0;
      tx_data_oe_o <= 1'b0;
      conv_pend <= 1'b0;
      conv_start_o <= 1'b0;
      null_cycle_o <= 1'b0;
      first_edge <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      null_cycle_o <= 1'b0;
      if (tx_sync_rise)
      begin
        tx_data_oe_o <= 1'b1; // [R2] [R4]
        conv_pend <= 1'b1;
        first_edge <= 1'b1;
        tx_cnt <= `APCM_BIT_CNT_W'd0;
        // the sync edge itself presents the first bit [R8]
        tx_data_o <= tx_shift[`APCM_SIGN_POS]; // [R24]
      end
      else if (tx_sync_fall | ~tx_sync)
        tx_data_oe_o <= 1'b0; // [R5] [R4]
      else if (tx_clk_rise && tx_cnt < `APCM_WORD_BITS - 1)
      begin
        if (first_edge && txc_s[1] && txs_d)
          first_edge <= 1'b0;
        tx_cnt <= tx_cnt + `APCM_BIT_CNT_W'd1;
        tx_shift <= {tx_shift[`APCM_WORD_BITS-2:0], 1'b0}; // [R3] [R7]
        tx_data_o <= tx_shift[`APCM_WORD_BITS-2]; // [R24]
      end
      // offset null and conversion start pulse together on the next conversion-clock edge
      if (conv_pend && mclk_en)
      begin
        conv_pend <= 1'b0;
        null_cycle_o <= 1'b1; // [R21]
        conv_start_o <= 1'b1; // [R2]
        if (~tx_sync)
          tx_shift <= {sample_sign_i, apcm_compress(sample_mag_i)}; // [R15] [R18] [R21]
      end
      if (tx_sync_fall)
        tx_shift <= {sample_sign_i, apcm_compress(sample_mag_i)}; // [R15] [R18]
    end
  end

  // receive side
  reg [`APCM_WORD_BITS-1:0] rx_shift;
  reg [`APCM_BIT_CNT_W-1:0] rx_cnt;
  reg rx_slave;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_shift <= {`APCM_WORD_BITS{1'b0}};
      rx_cnt <= `APCM_BIT_CNT_W'd0;
      rx_slave <= 1'b0;
      rx_word_o <= `APCM_IDLE_WORD;
      rx_word_valid_o <= 1'b0;
      rx_sign_o <= 1'b0;
      rx_mag_o <= 12'h000;
    end
    else
    begin
      rx_word_valid_o <= 1'b0;
      if (rx_sync_rise)
      begin
        rx_cnt <= `APCM_BIT_CNT_W'd0;
        if (rxc_s[1])
        begin
          // clock already high: sync edge is the first capture edge [R14] [R23]
          rx_slave <= rxd_s[1];
          rx_shift <= {rx_shift[`APCM_WORD_BITS-2:0], rxd_s[1]};
          rx_cnt <= `APCM_BIT_CNT_W'd1;
        end
      end
      else if (rx_sync && rx_clk_rise && rx_cnt < `APCM_WORD_BITS)
      begin
        rx_slave <= rxd_s[1]; // [R13] [R9]
        rx_shift <= {rx_shift[`APCM_WORD_BITS-2:0], rxd_s[1]}; // [R24]
        rx_cnt <= rx_cnt + `APCM_BIT_CNT_W'd1; // [R10]
      end
      if (rx_sync_fall)
      begin
        rx_word_o <= rx_shift; // [R11] [R19]
        rx_word_valid_o <= 1'b1; // [R11]
        rx_sign_o <= rx_shift[`APCM_SIGN_POS]; // [R18]
        rx_mag_o <= apcm_expand(rx_shift[`APCM_SEG_MSB:`APCM_STEP_LSB]); // [R15] [R19]
      end
    end
  end

endmodule

// *** apcm_pcm_mux.sv ***
`timescale 1ns/100ps
module apcm_pcm_mux (
  input wire clk_i,
  input wire line_i,
  output reg txs_o,
  output reg txc_o,
  output reg rxs_o,
  output reg rxc_o,
  output reg rxd_o
);
  integer k;
  initial {txs_o, txc_o, rxs_o, rxc_o, rxd_o} = 5'h0;
  task tx_frame(output [7:0] w);
    begin
      txs_o <= 1'b1;
      for (k = 0; k < 64; k = k + 1)
      begin
        @(posedge clk_i);
        if (k % 8 == 7) w = {w[6:0], line_i};
        txc_o <= k >= 7 && k < 63 && (k + 1) % 8 < 4;
      end
      txs_o <= 1'b0;
      repeat (16) @(posedge clk_i);
    end
  endtask
  task rx_frame(input [7:0] w);
    begin
      rxs_o <= 1'b1;
      rxd_o <= w[7];
      for (k = 0; k < 64; k = k + 1)
      begin
        @(posedge clk_i);
        rxc_o <= k % 8 >= 3 && k % 8 < 7;
        if (k % 8 == 7 && k < 56) rxd_o <= w[6 - k / 8];
      end
      rxs_o <= 1'b0;
      rxd_o <= ~rxd_o;
      repeat (3061) @(posedge clk_i);
    end
  endtask
endmodule

// *** apcm_serial_port_sva.sv ***
`timescale 1ns/100ps
module apcm_serial_port_sva (
  input wire clk_i,
  input wire reset_i,
  input wire tx_frame_sync_i,
  input wire tx_bit_clock_i,
  input wire rx_frame_sync_i,
  input wire tx_data_o,
  input wire tx_data_oe_o,
  input wire conv_start_o,
  input wire null_cycle_o,
  input wire [7:0] rx_word_o,
  input wire rx_word_valid_o,
  input wire rx_sign_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_tx_up;
    $rose(tx_frame_sync_i);
  endsequence
  sequence s_rx_dn;
    $fell(rx_frame_sync_i);
  endsequence
  a_tx_enable: assert property (s_tx_up |-> ##[1:4] tx_data_oe_o) else $error("no enable");
  a_conv_start: assert property (s_tx_up |-> ##[1:16] conv_start_o) else $error("no start");
  a_oe_quiet: assert property (!tx_frame_sync_i && !$past(tx_frame_sync_i) && !$past(tx_frame_sync_i, 2)
    && !$past(tx_frame_sync_i, 3) |-> !tx_data_oe_o) else $error("driven while idle");
  a_null_pair: assert property (conv_start_o == null_cycle_o) else $error("null unpaired");
  a_shift_edge: assert property ($changed(tx_data_o) && tx_data_oe_o && $past(tx_data_oe_o)
    |-> $past(tx_bit_clock_i, 2)) else $error("shift without clock");
  a_rx_decode: assert property (s_rx_dn |-> ##[1:5] rx_word_valid_o) else $error("no word");
  a_rx_after: assert property (rx_word_valid_o |-> !$past(rx_frame_sync_i)) else $error("early word");
  a_rx_hold: assert property (!rx_word_valid_o |-> $stable(rx_word_o)) else $error("word moved");
  a_rx_sign: assert property (rx_word_valid_o |-> rx_sign_o == rx_word_o[7]) else $error("bad sign");
endmodule

// *** test_apcm_serial_port.sv ***
`timescale 1ns/100ps
module test_apcm_serial_port;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg sample_sign_i = 1'b0;
  reg [11:0] sample_mag_i = 12'h000;
  reg [7:0] got;
  reg [7:0] prev;
  reg [7:0] w;
  wire tx_frame_sync_i, tx_bit_clock_i, rx_frame_sync_i, rx_bit_clock_i, rx_data_i;
  wire tx_data_o, tx_data_oe_o, conv_start_o, null_cycle_o, rx_word_valid_o, rx_sign_o;
  wire [7:0] rx_word_o;
  wire [11:0] rx_mag_o;
  wire line = tx_data_oe_o ? tx_data_o : 1'bz;
  integer fail_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer i;
  integer n;
  initial forever #20 clk_i = ~clk_i;
  apcm_pcm_mux i_apcm_pcm_mux (.clk_i, .line_i(line), .txs_o(tx_frame_sync_i), .txc_o(tx_bit_clock_i),
    .rxs_o(rx_frame_sync_i), .rxc_o(rx_bit_clock_i), .rxd_o(rx_data_i));
  apcm_serial_port i_apcm_serial_port (.clk_i, .reset_i, .tx_frame_sync_i, .tx_bit_clock_i, .rx_frame_sync_i,
    .rx_bit_clock_i, .rx_data_i, .sample_sign_i, .sample_mag_i, .tx_data_o, .tx_data_oe_o, .conv_start_o,
    .null_cycle_o, .rx_word_o, .rx_word_valid_o, .rx_sign_o, .rx_mag_o);
  function [7:0] enc(input s, input [11:0] m);
    integer g;
    integer t;
    begin
      g = 0;
      while (g < 7 && m >= (16 << g)) g = g + 1;
      t = (m >= 2048) ? 15 : m >> (g > 1 ? g - 1 : 0);
      enc = {s, g[2:0] ^ 3'b101, t[3:0]};
    end
  endfunction
  function [11:0] dec(input [7:0] v);
    integer s;
    begin
      s = v[6:4] ^ 3'b101;
      dec = s == 0 ? v[3:0] : s == 1 ? 16 + v[3:0] : (33 + 2 * v[3:0]) << (s - 2);
    end
  endfunction
  task check(input [63:0] nm, input [11:0] seen, input [11:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  initial
  begin
    n = $urandom(32'h2818);
    prev = 8'h80;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      @(posedge clk_i);
      sample_sign_i <= $urandom;
      sample_mag_i <= i == 0 ? 12'h000 : i == 1 ? 12'h0fff : i == 2 ? 12'h0020 : $urandom;
      @(posedge clk_i);
      i_apcm_pcm_mux.tx_frame(got);
      check("tx word", got, prev);
      prev = enc(sample_sign_i, sample_mag_i);
    end
    $display("tx test done");
    for (i = 0; i < 10; i = i + 1)
    begin
      w = $urandom;
      if (i < 8) w[6:4] = i;
      fork
        i_apcm_pcm_mux.rx_frame(w);
        begin
          n = 0;
          while (rx_word_valid_o !== 1'b1 && n < 300)
          begin
            @(negedge clk_i);
            n = n + 1;
          end
          if (n >= 300) fail_count = fail_count + 1;
          check("rx word", rx_word_o, w);
          check("rx sign", rx_sign_o, w[7]);
          check("rx mag", rx_mag_o, dec(w));
        end
      join
    end
    $display("rx test done");
    results;
  end
endmodule
bind apcm_serial_port apcm_serial_port_sva i_apcm_serial_port_sva (.clk_i, .reset_i, .tx_frame_sync_i,
  .tx_bit_clock_i, .rx_frame_sync_i, .tx_data_o, .tx_data_oe_o, .conv_start_o, .null_cycle_o, .rx_word_o,
  .rx_word_valid_o, .rx_sign_o);
